/* rtl/soio_pkg.sv */
// Types for the safe torque off input and feedback logic
// Assumes the register header is on the include path
`include "soio_regs.svh"

package soio_pkg;

   // ----------------------------------------
   // Stop sequencing states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SOIO_SHUTOFF,
      SOIO_RELEASED,
      SOIO_BRAKING
   } soio_state_t;

   // ----------------------------------------
   // Software control word
   // ----------------------------------------
   typedef struct packed {
      logic clr_err;
      logic no_detect;
      logic servo_on;
   } soio_ctrl_t;

   // ----------------------------------------
   // Software visible status word
   // ----------------------------------------
   typedef struct packed {
      logic timing_err;
      logic braking;
      logic servo_act;
      logic series_on;
      logic torque_off;
      logic ch_b_off;
      logic ch_a_off;
   } soio_status_t;

endpackage

/* rtl/soio_regs.svh */
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by its bare name from the package and the design
`ifndef SOIO_REGS_SVH
`define SOIO_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SOIO_ADDR_W 4
`define SOIO_OFS_CTRL 4'h0
`define SOIO_OFS_STATUS 4'h4
`define SOIO_CTRL_RESET 3'h0

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SOIO_CTRL_SERVO_ON 0
`define SOIO_CTRL_NO_DETECT 1
`define SOIO_CTRL_CLR_ERR 2

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SOIO_ST_CH_A_OFF 0
`define SOIO_ST_CH_B_OFF 1
`define SOIO_ST_TORQUE_OFF 2
`define SOIO_ST_SERIES_ON 3
`define SOIO_ST_SERVO_ACT 4
`define SOIO_ST_BRAKING 5
`define SOIO_ST_TIMING_ERR 6
`define SOIO_STATUS_W 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define SOIO_CLK_MHZ 40
`define SOIO_TEST_PULSE_MAX_US 1000
`define SOIO_TEST_PULSE_CYCLES (`SOIO_TEST_PULSE_MAX_US * `SOIO_CLK_MHZ)

`endif

/* rtl/soio_safe_torque_off.sv */
// Dual channel safe torque off input, feedback and stop sequencing logic
// Assumes static shut-off pin levels, a same-clock speed flag and gate drive
//
// Functional notes
// - Channel A open means shut-off request; closed means released.
// - Channel B open means shut-off request; closed means released.
// - Feedback A closes while channel A is shut off, opens when released.
// - Feedback B closes while channel B is shut off, opens when released.
// - Torque off if either input open; release needs both closed, no alarm, warning or timing error.
// - Series feedback path conducts only when both channels are shut off.
// - Opening inputs while the motor turns stops it by dynamic braking.
`timescale 1ns/100ps
`default_nettype none
`include "soio_regs.svh"

module soio_safe_torque_off
   import soio_pkg::*;
#(
   parameter int GATE_W = 6,
   parameter int MISMATCH_CYCLES = `SOIO_TEST_PULSE_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic shutoff_input_a,
   input wire logic shutoff_input_b,
   input wire logic alarm_present,
   input wire logic warning_present,
   input wire logic motor_moving,
   input wire logic [GATE_W-1:0] gate_drive_in,
   input wire logic [`SOIO_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic shutoff_feedback_a,
   output logic shutoff_feedback_b,
   output logic feedback_series_on,
   output logic torque_off,
   output logic dyn_brake_on,
   output logic timing_error,
   output logic [GATE_W-1:0] gate_drive_out
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Inputs are high while the contact is closed
   logic [1:0] pin_meta_reg;
   logic [1:0] pin_sync_reg;
   wire logic [1:0] pin_raw;

   assign pin_raw = {shutoff_input_b, shutoff_input_a};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               pin_meta_reg[gi] <= 1'b0;
               pin_sync_reg[gi] <= 1'b0;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Channel decode
   // ----------------------------------------
   // Open contact, or reset, reads as shut-off: the safe side
   wire logic ch_a_off;
   wire logic ch_b_off;
   wire logic any_off;
   wire logic one_off;
   wire logic fault_present;
   wire logic torque_off_next;

   assign ch_a_off = ~pin_sync_reg[0];
   assign ch_b_off = ~pin_sync_reg[1];
   assign any_off = ch_a_off | ch_b_off;
   assign one_off = ch_a_off ^ ch_b_off;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   soio_ctrl_t ctrl_reg;
   logic [31:0] reg_rdata_reg;
   logic timing_err_reg;
   soio_status_t status_word;
   wire logic wr_ctrl;
   wire logic rd_ctrl;
   wire logic rd_status;
   wire logic clr_err_pulse;
   wire logic [31:0] rd_value;

   function automatic logic addr_hit(input logic [`SOIO_ADDR_W-1:0] a,
                                     input logic [`SOIO_ADDR_W-1:0] ofs);
      addr_hit = (a == ofs);
   endfunction

   assign wr_ctrl = reg_write & addr_hit(reg_addr, `SOIO_OFS_CTRL);
   assign rd_ctrl = reg_read & addr_hit(reg_addr, `SOIO_OFS_CTRL);
   assign rd_status = reg_read & addr_hit(reg_addr, `SOIO_OFS_STATUS);
   assign clr_err_pulse = wr_ctrl & reg_wdata[`SOIO_CTRL_CLR_ERR];

   // Clear bit is a strobe; it never reads back as set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `SOIO_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg.servo_on <= reg_wdata[`SOIO_CTRL_SERVO_ON];
         ctrl_reg.no_detect <= reg_wdata[`SOIO_CTRL_NO_DETECT];
         ctrl_reg.clr_err <= 1'b0;
      end
   end

   // Unmapped reads return zero
   assign rd_value = rd_ctrl ? {29'h0, 1'b0, ctrl_reg.no_detect, ctrl_reg.servo_on} :
                     rd_status ? {25'h0, status_word} : 32'h0;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_reg <= 32'h0;
      end else begin
         reg_rdata_reg <= rd_value;
      end
   end

   assign reg_rdata = reg_rdata_reg;

   // ----------------------------------------
   // Channel mismatch watch
   // ----------------------------------------
   // One channel open beyond the test pulse limit is a wiring or sequence fault
   logic [31:0] mis_cnt_reg;
   wire logic mis_limit;
   wire logic err_set;

   assign mis_limit = (mis_cnt_reg >= 32'(MISMATCH_CYCLES));
   // Gated by the live mismatch: the saturated count lingers one cycle after it ends
   assign err_set = mis_limit & one_off & ~ctrl_reg.no_detect;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mis_cnt_reg <= 32'h0;
      end else if (!one_off) begin
         mis_cnt_reg <= 32'h0;
      end else if (!mis_limit) begin
         mis_cnt_reg <= mis_cnt_reg + 32'h1;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         timing_err_reg <= 1'b0;
      end else if (err_set) begin
         timing_err_reg <= 1'b1;
      end else if (clr_err_pulse) begin
         timing_err_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Torque state and servo enable
   // ----------------------------------------
   logic torque_off_reg;
   logic servo_act_reg;
   wire logic servo_act_next;

   assign fault_present = alarm_present | warning_present | timing_err_reg;
   assign torque_off_next = any_off | fault_present;
   // Servo-on only takes effect once torque is released
   assign servo_act_next = ctrl_reg.servo_on & ~torque_off_next;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         torque_off_reg <= 1'b1;
         servo_act_reg <= 1'b0;
      end else begin
         torque_off_reg <= torque_off_next;
         servo_act_reg <= servo_act_next;
      end
   end

   // ----------------------------------------
   // Stop sequencing
   // ----------------------------------------
   // Braking stays until the speed flag drops, even if inputs reclose
   soio_state_t state_reg;
   soio_state_t state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SOIO_RELEASED: begin
            if (torque_off_next && motor_moving) begin
               state_next = SOIO_BRAKING;
            end else if (torque_off_next) begin
               state_next = SOIO_SHUTOFF;
            end
         end
         SOIO_BRAKING: begin
            if (!motor_moving) begin
               state_next = SOIO_SHUTOFF;
            end
         end
         SOIO_SHUTOFF: begin
            if (!torque_off_next) begin
               state_next = SOIO_RELEASED;
            end
         end
         default: begin
            state_next = SOIO_SHUTOFF;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= SOIO_SHUTOFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   logic fb_a_reg;
   logic fb_b_reg;
   logic brake_reg;
   logic [GATE_W-1:0] gate_reg;
   wire logic gate_allow;

   assign gate_allow = servo_act_next & (state_next == SOIO_RELEASED);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fb_a_reg <= 1'b1;
         fb_b_reg <= 1'b1;
         brake_reg <= 1'b0;
         gate_reg <= '0;
      end else begin
         fb_a_reg <= ch_a_off;
         fb_b_reg <= ch_b_off;
         brake_reg <= (state_next == SOIO_BRAKING);
         gate_reg <= gate_allow ? gate_drive_in : '0;
      end
   end

   assign shutoff_feedback_a = fb_a_reg;
   assign shutoff_feedback_b = fb_b_reg;
   // Series path conducts only when both contacts are open
   assign feedback_series_on = fb_a_reg & fb_b_reg;
   assign torque_off = torque_off_reg;
   assign dyn_brake_on = brake_reg;
   assign timing_error = timing_err_reg;
   assign gate_drive_out = gate_reg;

   assign status_word = '{timing_err: timing_err_reg, braking: brake_reg,
                          servo_act: servo_act_reg, series_on: feedback_series_on,
                          torque_off: torque_off_reg, ch_b_off: fb_b_reg,
                          ch_a_off: fb_a_reg};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   chk_fb_a_follow: assert property (
      $fell(shutoff_input_a) |-> ##3 shutoff_feedback_a)
      else $error("feedback A not closed after input A opened");

   chk_fb_b_follow: assert property (
      $rose(shutoff_input_b) ##1 shutoff_input_b [*2]
      |=> shutoff_feedback_b == 1'b0)
      else $error("feedback B not open after input B closed");

   chk_ch_a_decode: assert property (
      shutoff_feedback_a == ~$past(pin_sync_reg[0]))
      else $error("channel A decode wrong");

   chk_ch_b_decode: assert property (
      !$past(pin_sync_reg[1]) |-> shutoff_feedback_b)
      else $error("channel B open not shown as shut-off");

   chk_torque_any_off: assert property (
      (!shutoff_input_a || !shutoff_input_b) |-> ##3 torque_off)
      else $error("torque not off with an input open");

   chk_torque_release: assert property (
      !torque_off |-> !shutoff_feedback_a && !shutoff_feedback_b && !timing_error)
      else $error("torque released without both channels released");

   chk_series_path: assert property (
      feedback_series_on |-> shutoff_feedback_a && shutoff_feedback_b)
      else $error("series path conducts with a channel released");

   chk_brake_entry: assert property (
      state_reg == SOIO_RELEASED && torque_off_next && motor_moving
      |=> dyn_brake_on)
      else $error("no dynamic brake on shut-off while moving");

   chk_brake_hold: assert property (
      dyn_brake_on && motor_moving |=> dyn_brake_on)
      else $error("dynamic brake dropped while motor still moving");

   chk_gate_block: assert property (
      torque_off |-> gate_drive_out == '0)
      else $error("gate drive active while torque off");

   chk_servo_ignore: assert property (
      torque_off_next |=> !servo_act_reg)
      else $error("servo-on accepted during shut-off");

   chk_err_set: assert property (
      err_set |=> timing_error)
      else $error("mismatch beyond limit not flagged");

   chk_err_off_sel: assert property (
      ctrl_reg.no_detect && !timing_error |=> !timing_error)
      else $error("timing error raised with detection disabled");

   cov_released: cover property (!torque_off ##1 torque_off);
   cov_braking: cover property (dyn_brake_on ##1 !dyn_brake_on);
   cov_single_channel: cover property (shutoff_feedback_a && !shutoff_feedback_b);
   cov_timing_err: cover property ($rose(timing_error));

endmodule
`default_nettype wire

/* testbench/soio_relay_model.sv */
// External safety relay driving the two shut-off contacts
// Assumes the bench commands it on rising clock edges
`timescale 1ns/100ps
`default_nettype none

module soio_relay_model #(
   parameter int PULSE_CYCLES = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic open_req,
   input wire logic skew_a,
   input wire logic pulse_go,
   output logic shutoff_input_a,
   output logic shutoff_input_b
);
   // ----------------------------------------
   // Test pulse timer
   // ----------------------------------------
   int pulse_cnt;
   wire logic pulse_open;

   // Width kept at or under 1 ms; both contacts open together, so the drive turns torque off but flags no timing error
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pulse_cnt <= 0;
      end else if (pulse_go) begin
         pulse_cnt <= PULSE_CYCLES;
      end else if (pulse_cnt > 0) begin
         pulse_cnt <= pulse_cnt - 1;
      end
   end
   assign pulse_open = (pulse_cnt > 0);

   // ----------------------------------------
   // Contacts, 1 = closed
   // ----------------------------------------
   // Both channels open together; skew_a only models a wiring fault
   assign shutoff_input_a = ~(open_req | pulse_open | skew_a);
   assign shutoff_input_b = ~(open_req | pulse_open);
endmodule

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the safe torque off logic
// Assumes the relay model and a short mismatch count of 20 cycles
`timescale 1ns/100ps
`default_nettype none
`include "soio_regs.svh"

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module tb;
   import soio_pkg::*;
   logic clock, rstn, alarm_present, warning_present, motor_moving;
   logic open_req, skew_a, pulse_go, reg_write, reg_read;
   logic [5:0] gate_drive_in;
   logic [5:0] gate_drive_out;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic shutoff_input_a, shutoff_input_b, shutoff_feedback_a, shutoff_feedback_b;
   logic feedback_series_on, torque_off, dyn_brake_on, timing_error;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;

   // ----------------------------------------
   // Clock, parts and timeout
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   soio_relay_model #(.PULSE_CYCLES(8)) i_relay (.clock(clock), .rstn(rstn),
      .open_req(open_req), .skew_a(skew_a), .pulse_go(pulse_go),
      .shutoff_input_a(shutoff_input_a), .shutoff_input_b(shutoff_input_b));

   soio_safe_torque_off #(.GATE_W(6), .MISMATCH_CYCLES(20)) i_dut (.clock(clock),
      .rstn(rstn), .shutoff_input_a(shutoff_input_a), .shutoff_input_b(shutoff_input_b),
      .alarm_present(alarm_present), .warning_present(warning_present),
      .motor_moving(motor_moving), .gate_drive_in(gate_drive_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .shutoff_feedback_a(shutoff_feedback_a),
      .shutoff_feedback_b(shutoff_feedback_b), .feedback_series_on(feedback_series_on),
      .torque_off(torque_off), .dyn_brake_on(dyn_brake_on), .timing_error(timing_error),
      .gate_drive_out(gate_drive_out));

   // Whole run is about 180 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      `CHK("reg_rdata", exp, reg_rdata)
   endtask

   // Expected {feedback_a, feedback_b, series, torque_off}
   task automatic pins(input logic [3:0] exp);
      `CHK("pins", exp, {shutoff_feedback_a, shutoff_feedback_b, feedback_series_on, torque_off})
   endtask

   task automatic end_test(input string nm);
      $display("test %s done, mismatches so far %0d", nm, n_mismatch);
   endtask

   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      {alarm_present, warning_present, motor_moving, skew_a, pulse_go} = 5'h00;
      {reg_write, reg_read} = 2'h0;
      open_req = 1'b1;
      gate_drive_in = 6'h00;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      wait_cyc(2);
      pins(4'hF);
      reg_wr(`SOIO_OFS_CTRL, 32'h1);
      gate_drive_in <= 6'h2A;
      wait_cyc(4);
      `CHK("gate_shut", 6'h00, gate_drive_out)
      reg_rd(`SOIO_OFS_STATUS, 32'h0F);
      end_test("open");
      @(posedge clock);
      open_req <= 1'b0;
      wait_cyc(5);
      pins(4'h0);
      `CHK("gate_run", 6'h2A, gate_drive_out)
      reg_rd(`SOIO_OFS_STATUS, 32'h10);
      end_test("release");
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         {alarm_present, warning_present} <= (i == 0) ? 2'b10 : 2'b01;
         wait_cyc(4);
         pins(4'h1);
         `CHK("gate_alarm", 6'h00, gate_drive_out)
         {alarm_present, warning_present} <= 2'b00;
         wait_cyc(4);
         pins(4'h0);
      end
      end_test("alarm");
      @(posedge clock);
      skew_a <= 1'b1;
      wait_cyc(12);
      pins(4'h9);
      `CHK("err_short", 1'b0, timing_error)
      skew_a <= 1'b0;
      wait_cyc(5);
      pins(4'h0);
      skew_a <= 1'b1;
      wait_cyc(30);
      reg_rd(`SOIO_OFS_STATUS, 32'h45);
      skew_a <= 1'b0;
      wait_cyc(5);
      pins(4'h1);
      reg_wr(`SOIO_OFS_CTRL, 32'h5);
      wait_cyc(3);
      pins(4'h0);
      reg_rd(`SOIO_OFS_CTRL, 32'h1);
      reg_wr(`SOIO_OFS_CTRL, 32'h3);
      @(posedge clock);
      skew_a <= 1'b1;
      wait_cyc(30);
      `CHK("err_off", 1'b0, timing_error)
      skew_a <= 1'b0;
      reg_wr(`SOIO_OFS_CTRL, 32'h1);
      end_test("mismatch");
      @(posedge clock);
      pulse_go <= 1'b1;
      @(posedge clock);
      pulse_go <= 1'b0;
      wait_cyc(5);
      pins(4'hF);
      wait_cyc(10);
      pins(4'h0);
      `CHK("err_pulse", 1'b0, timing_error)
      end_test("pulse");
      motor_moving <= 1'b1;
      wait_cyc(2);
      open_req <= 1'b1;
      wait_cyc(5);
      `CHK("brake_on", 1'b1, dyn_brake_on)
      reg_rd(`SOIO_OFS_STATUS, 32'h2F);
      motor_moving <= 1'b0;
      wait_cyc(3);
      `CHK("brake_off", 1'b0, dyn_brake_on)
      open_req <= 1'b0;
      wait_cyc(6);
      pins(4'h0);
      // Controlled stop: speed already zero before the contacts open
      open_req <= 1'b1;
      wait_cyc(5);
      `CHK("brake_ctl", 1'b0, dyn_brake_on)
      pins(4'hF);
      end_test("stop");
      reg_wr(4'hC, 32'h7);
      reg_rd(4'hC, 32'h0);
      reg_rd(`SOIO_OFS_CTRL, 32'h1);
      end_test("unmapped");
      finish_test();
   end
endmodule

`default_nettype wire
